/* common/fbp_cyc_if.sv */
interface fbp_cyc_if #(parameter int AW = 24);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic          done;
  logic [15:0]   rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave  (input req, wr, addr, wdata, output done, rdata);
endinterface

/* common/fbp_pkg.sv */
package fbp_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ     = 10;
  localparam int T_WP_NS     = 120;
  localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RD_NS     = 250;
  localparam int RD_CYC      = (T_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RST_NS    = 1000;
  localparam int RST_CYC     = (T_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int ADD_WIN_US  = 50;
  // Strictly less than the window, so one cycle short of it
  localparam int ADD_WIN_CYC = ADD_WIN_US * CLK_MHZ - 1;
  // Margin for the add write to reach its strobe edge
  localparam int ADD_ACC_CYC = ADD_WIN_CYC - WP_CYC - 4;

  // ==========================================================
  // Flash command words and unlock offsets
  // ==========================================================
  localparam logic [11:0] A_UNLK1 = 12'h555;
  localparam logic [11:0] A_UNLK2 = 12'h2AA;
  localparam logic [15:0] D_UNLK1 = 16'h00AA;
  localparam logic [15:0] D_UNLK2 = 16'h0055;
  localparam logic [15:0] D_LOAD  = 16'h0025;
  localparam logic [15:0] D_CONF  = 16'h0029;
  localparam logic [15:0] D_ABRST = 16'h00F0;
  localparam logic [15:0] D_ESET  = 16'h0080;
  localparam logic [15:0] D_SERS  = 16'h0030;
  localparam int          BUF_WORDS = 32;
  localparam int          PAGE_LSB  = 5;

  // ==========================================================
  // Flash status bit positions
  // ==========================================================
  localparam int TOGGLE_BIT_POS     = 6;
  localparam int TIME_LIMIT_POS     = 5;
  localparam int ERASE_TIMER_POS    = 3;
  localparam int BUFFER_ABORT_POS   = 1;

  // ==========================================================
  // Register map and status layout
  // ==========================================================
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_CNT  = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0C;
  localparam logic [7:0] R_RDAT = 8'h10;
  localparam logic [7:0] R_BUF  = 8'h80;
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_ERR   = 3;
  localparam int ST_REJ   = 4;
  localparam int ST_WIN   = 5;
  localparam int ST_ETMR  = 6;
  localparam int ST_INTR  = 7;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_PROG  = 3'h1,
    OP_ERASE = 3'h2,
    OP_ADD   = 3'h3,
    OP_ABRST = 3'h4,
    OP_HWRST = 3'h5
  } fbp_op_t;
endpackage

/* hw/fbp_bus_cycle.sv */
module fbp_bus_cycle #(
  parameter int AW = 24
) (
  input  logic          pclk,
  input  logic          presetn,
  fbp_cyc_if.slave      cyc,
  output logic [AW-1:0] fl_addr,
  output logic [15:0]   fl_dq_o,
  output logic          fl_dq_oe,
  input  logic [15:0]   fl_dq_i,
  output logic          fl_ce_n,
  output logic          fl_we_n,
  output logic          fl_oe_n
);
  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_SET  = 3'h1,
    P_STRB = 3'h2,
    P_HOLD = 3'h3,
    P_RD   = 3'h4
  } fbp_ph_t;

  typedef struct packed {
    fbp_ph_t       ph;
    logic [3:0]    cnt;
    logic [AW-1:0] ca;
    logic [15:0]   cd;
    logic          oe;
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
    logic          done;
    logic [15:0]   rdata;
    logic [15:0]   s1;
    logic [15:0]   s2;
  } fbp_cyc_st_t;

  fbp_cyc_st_t s_q;
  fbp_cyc_st_t s_d;

  // ==========================================================
  // One bus cycle: setup, strobe, hold; reads wait for sync
  // ==========================================================
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.s1 = fl_dq_i;
    s_d.s2 = s_q.s1;
    case (s_q.ph)
      P_IDLE:
        if (cyc.req)
        begin
          s_d.ca = cyc.addr;
          s_d.cd = cyc.wdata;
          s_d.ce_n = 1'b0;
          s_d.oe = cyc.wr;
          s_d.oe_n = cyc.wr;
          s_d.cnt = 4'(fbp_pkg::RD_CYC + 1);
          s_d.ph = cyc.wr ? P_SET : P_RD;
        end
      P_SET:
      begin
        s_d.we_n = 1'b0;
        s_d.cnt = 4'(fbp_pkg::WP_CYC - 1);
        s_d.ph = P_STRB;
      end
      P_STRB:
        if (s_q.cnt == 4'h0)
        begin
          s_d.we_n = 1'b1;
          s_d.ph = P_HOLD;
        end
        else
          s_d.cnt = s_q.cnt - 4'h1;
      P_HOLD:
      begin
        s_d.ce_n = 1'b1;
        s_d.oe = 1'b0;
        s_d.done = 1'b1;
        s_d.ph = P_IDLE;
      end
      P_RD:
        // Data is read only after two sync stages have settled
        if (s_q.cnt == 4'h0)
        begin
          s_d.rdata = s_q.s2;
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.done = 1'b1;
          s_d.ph = P_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - 4'h1;
      default: s_d.ph = P_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.ce_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign cyc.done  = s_q.done;
  assign cyc.rdata = s_q.rdata;
  assign fl_addr   = s_q.ca;
  assign fl_dq_o   = s_q.cd;
  assign fl_dq_oe  = s_q.oe;
  assign fl_ce_n   = s_q.ce_n;
  assign fl_we_n   = s_q.we_n;
  assign fl_oe_n   = s_q.oe_n;

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_strobe;
    !fl_we_n [*2] ##1 fl_we_n;
  endsequence

  a_we_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_n) |-> s_strobe)
    else $error("write strobe width wrong");
  a_we_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_n |-> fl_dq_oe && !fl_ce_n && $stable(fl_addr)
      && $stable(fl_dq_o))
    else $error("address or data moved under strobe");
endmodule

/* hw/fbp_flash_host.sv */
// Overview of operation
// - Buffer program opens with AA at 555, 55 at 2AA, then 25 at sector.
// - Fourth write carries word count minus one; count is 1 to 32 words.
// - After N data writes, confirm 29 goes to sector; 6 to 37 cycles.
// - Host should fill the buffer with as many words as it can.
// - Abort recovery is AA, 55, then F0 at 555; back to array read.
// - All loaded addresses lie in one 0x20-word buffer page.
// - Sector erase: AA, 55, 80, AA, 55, then 30 at sector.
// - Host writes each extra sector erase under 50 us after the last.
// - Hardware reset stops erase; host reissues the erase afterwards. This block does not reissue it: it sets ST_INTR and goes idle.
module fbp_flash_host #(
  parameter int AW = 24
) (
  input  logic          pclk,
  input  logic          presetn,
  input  logic          psel,
  input  logic          penable,
  input  logic          pwrite,
  input  logic [7:0]    paddr,
  input  logic [31:0]   pwdata,
  output logic [31:0]   prdata,
  output logic          pready,
  output logic          pslverr,
  output logic [AW-1:0] fl_addr,
  output logic [15:0]   fl_dq_o,
  output logic          fl_dq_oe,
  input  logic [15:0]   fl_dq_i,
  output logic          fl_ce_n,
  output logic          fl_we_n,
  output logic          fl_oe_n,
  output logic          fl_rst_n
);
  localparam logic [AW-1:0] U1 = {{(AW-12){1'b0}}, fbp_pkg::A_UNLK1};
  localparam logic [AW-1:0] U2 = {{(AW-12){1'b0}}, fbp_pkg::A_UNLK2};

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ISSUE = 3'h1,
    S_WAIT  = 3'h2,
    S_WIN   = 3'h3,
    S_RQ    = 3'h4,
    S_RW    = 3'h5,
    S_HRST  = 3'h6
  } fbp_hst_t;

  typedef struct packed {
    fbp_hst_t      st;
    fbp_pkg::fbp_op_t op;
    logic [5:0]    step;
    logic [5:0]    cnt;
    logic [AW-1:0] addr;
    logic [31:0][15:0] wbuf;
    logic          sec;
    logic [15:0]   r1;
    logic [15:0]   rdat;
    logic [9:0]    wtmr;
    logic [3:0]    rtmr;
    logic [7:0]    fl;
    logic          req;
    logic          wr;
    logic [AW-1:0] ca;
    logic [15:0]   cd;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          rst_n;
  } fbp_host_st_t;

  fbp_host_st_t  s_q;
  fbp_host_st_t  s_d;
  fbp_cyc_if #(.AW(AW)) cyc ();

  logic          wacc;
  logic          go;
  logic          pgok;
  logic          last;
  fbp_pkg::fbp_op_t opw;
  logic [31:0]   rd;
  logic [7:0]    stat;
  logic [5:0]    ix;
  logic [AW-1:0] wa;
  logic [15:0]   wd;

  fbp_bus_cycle #(.AW(AW)) u_cyc (
    .pclk    (pclk),
    .presetn (presetn),
    .cyc     (cyc),
    .fl_addr (fl_addr),
    .fl_dq_o (fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i (fl_dq_i),
    .fl_ce_n (fl_ce_n),
    .fl_we_n (fl_we_n),
    .fl_oe_n (fl_oe_n)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // ========================================================
    // Command word for the current step
    // ========================================================
    ix = s_q.step - 6'h04;
    {wa, wd} = {U1, fbp_pkg::D_UNLK1};
    case (s_q.op)
      fbp_pkg::OP_PROG:
        case (s_q.step)
          6'h00: {wa, wd} = {U1, fbp_pkg::D_UNLK1};
          6'h01: {wa, wd} = {U2, fbp_pkg::D_UNLK2};
          6'h02: {wa, wd} = {s_q.addr, fbp_pkg::D_LOAD};
          6'h03: {wa, wd} = {s_q.addr, 10'h000, s_q.cnt};
          default:
            if (s_q.step == s_q.cnt + 6'h05)
              {wa, wd} = {s_q.addr, fbp_pkg::D_CONF};
            else
              {wa, wd} = {s_q.addr + {{(AW-6){1'b0}}, ix},
                          s_q.wbuf[ix[4:0]]};
        endcase
      fbp_pkg::OP_ERASE:
        case (s_q.step)
          6'h01: {wa, wd} = {U2, fbp_pkg::D_UNLK2};
          6'h02: {wa, wd} = {U1, fbp_pkg::D_ESET};
          6'h04: {wa, wd} = {U2, fbp_pkg::D_UNLK2};
          6'h05: {wa, wd} = {s_q.addr, fbp_pkg::D_SERS};
          default: {wa, wd} = {U1, fbp_pkg::D_UNLK1};
        endcase
      fbp_pkg::OP_ABRST:
        case (s_q.step)
          6'h01: {wa, wd} = {U2, fbp_pkg::D_UNLK2};
          6'h02: {wa, wd} = {U1, fbp_pkg::D_ABRST};
          default: {wa, wd} = {U1, fbp_pkg::D_UNLK1};
        endcase
      default: {wa, wd} = {s_q.addr, fbp_pkg::D_SERS};
    endcase
    last = (s_q.op == fbp_pkg::OP_PROG && s_q.step == s_q.cnt + 6'h05)
        || (s_q.op == fbp_pkg::OP_ERASE && s_q.step == 6'h05)
        || (s_q.op == fbp_pkg::OP_ABRST && s_q.step == 6'h02)
        || (s_q.op == fbp_pkg::OP_ADD);
    // ========================================================
    // APB slave: one wait state, registered answer
    // ========================================================
    stat = s_q.fl;
    stat[fbp_pkg::ST_BUSY] = s_q.st != S_IDLE;
    stat[fbp_pkg::ST_WIN] = s_q.st == S_WIN;
    rd = 32'h0000_0000;
    if (paddr[7])
      rd = {16'h0000, s_q.wbuf[paddr[6:2]]};
    else
      case (paddr)
        fbp_pkg::R_CTRL: rd = {29'h0, s_q.op};
        fbp_pkg::R_ADDR: rd = 32'(s_q.addr);
        fbp_pkg::R_CNT:  rd = {26'h0, s_q.cnt};
        fbp_pkg::R_STAT: rd = {24'h0, stat};
        fbp_pkg::R_RDAT: rd = {16'h0000, s_q.rdat};
        default:         rd = 32'h0000_0000;
      endcase
    if (psel && penable && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = rd;
      s_d.pslverr = !paddr[7] && paddr > fbp_pkg::R_RDAT;
    end
    wacc = psel && penable && pwrite && s_q.pready;
    go = wacc && paddr == fbp_pkg::R_CTRL;
    opw = fbp_pkg::fbp_op_t'(pwdata[2:0]);
    if (wacc && paddr[7])
      s_d.wbuf[paddr[6:2]] = pwdata[15:0];
    if (wacc && paddr == fbp_pkg::R_ADDR
        && (s_q.st == S_IDLE || s_q.st == S_WIN))
      s_d.addr = pwdata[AW-1:0];
    if (wacc && paddr == fbp_pkg::R_CNT && s_q.st == S_IDLE)
      s_d.cnt = pwdata[5:0];
    // Clear first so that a hardware set in this cycle wins
    if (wacc && paddr == fbp_pkg::R_STAT)
      s_d.fl = s_q.fl & ~pwdata[7:0];
    // ========================================================
    // Sequencer
    // ========================================================
    case (s_q.st)
      S_IDLE: ;
      S_ISSUE:
      begin
        s_d.ca = wa;
        s_d.cd = wd;
        s_d.req = 1'b1;
        s_d.wr = 1'b1;
        s_d.st = S_WAIT;
      end
      S_WAIT:
        if (cyc.done && !last)
        begin
          s_d.step = s_q.step + 6'h01;
          s_d.st = S_ISSUE;
        end
        else if (cyc.done && s_q.op == fbp_pkg::OP_PROG)
        begin
          s_d.ca = s_q.addr + {{(AW-6){1'b0}}, s_q.cnt};
          s_d.sec = 1'b0;
          s_d.st = S_RQ;
        end
        else if (cyc.done && s_q.op == fbp_pkg::OP_ABRST)
        begin
          s_d.fl[fbp_pkg::ST_ABORT] = 1'b0;
          s_d.fl[fbp_pkg::ST_DONE] = 1'b1;
          s_d.st = S_IDLE;
        end
        else if (cyc.done)
        begin
          s_d.wtmr = 10'h000;
          s_d.st = S_WIN;
        end
      S_WIN:
      begin
        s_d.wtmr = s_q.wtmr + 10'h001;
        if (s_q.wtmr == 10'(fbp_pkg::ADD_WIN_CYC))
        begin
          s_d.ca = s_q.addr;
          s_d.sec = 1'b0;
          s_d.st = S_RQ;
        end
      end
      S_RQ:
      begin
        s_d.req = 1'b1;
        s_d.wr = 1'b0;
        s_d.st = S_RW;
      end
      S_RW:
        if (cyc.done)
        begin
          s_d.rdat = cyc.rdata;
          s_d.r1 = cyc.rdata;
          s_d.sec = 1'b1;
          s_d.st = S_RQ;
          s_d.fl[fbp_pkg::ST_ETMR] = cyc.rdata[fbp_pkg::ERASE_TIMER_POS];
          // Two reads with a steady toggle bit mean the device is idle
          if (s_q.sec && s_q.r1[fbp_pkg::TOGGLE_BIT_POS]
              == cyc.rdata[fbp_pkg::TOGGLE_BIT_POS])
          begin
            s_d.fl[fbp_pkg::ST_DONE] = 1'b1;
            s_d.st = S_IDLE;
          end
          // Abort and time-limit flags count only when two toggling status reads show them;
          // the first array word after completion may hold any bits
          else if (s_q.sec && s_q.op == fbp_pkg::OP_PROG
                   && s_q.r1[fbp_pkg::BUFFER_ABORT_POS]
                   && cyc.rdata[fbp_pkg::BUFFER_ABORT_POS])
          begin
            s_d.fl[fbp_pkg::ST_ABORT] = 1'b1;
            s_d.st = S_IDLE;
          end
          else if (s_q.sec && s_q.r1[fbp_pkg::TIME_LIMIT_POS]
                   && cyc.rdata[fbp_pkg::TIME_LIMIT_POS])
          begin
            s_d.fl[fbp_pkg::ST_ERR] = 1'b1;
            s_d.st = S_IDLE;
          end
        end
      S_HRST:
      begin
        s_d.rtmr = s_q.rtmr + 4'h1;
        if (s_q.rtmr == 4'(fbp_pkg::RST_CYC - 1))
        begin
          s_d.rst_n = 1'b1;
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
    // Program rejected when the count or page span is illegal
    pgok = !s_q.cnt[5]
        && {1'b0, s_q.addr[4:0]} + s_q.cnt <= 6'h1F;
    if (go && opw == fbp_pkg::OP_HWRST)
    begin
      s_d.fl[fbp_pkg::ST_INTR] = s_q.st != S_IDLE
        && (s_q.op == fbp_pkg::OP_ERASE || s_q.op == fbp_pkg::OP_ADD);
      s_d.rst_n = 1'b0;
      s_d.rtmr = 4'h0;
      s_d.st = S_HRST;
    end
    else if (go && ((s_q.st == S_IDLE && (opw == fbp_pkg::OP_ERASE
             || opw == fbp_pkg::OP_ABRST
             || (opw == fbp_pkg::OP_PROG && pgok)))
             || (s_q.st == S_WIN && opw == fbp_pkg::OP_ADD
             && s_q.wtmr < 10'(fbp_pkg::ADD_ACC_CYC))))
    begin
      s_d.op = opw;
      s_d.step = 6'h00;
      s_d.st = S_ISSUE;
    end
    else if (go)
      s_d.fl[fbp_pkg::ST_REJ] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.rst_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign cyc.req   = s_q.req;
  assign cyc.wr    = s_q.wr;
  assign cyc.addr  = s_q.ca;
  assign cyc.wdata = s_q.cd;
  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign fl_rst_n  = s_q.rst_n;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rst_low;
    !s_q.rst_n [*8];
  endsequence
  sequence s_erase_tail;
    ##[1:12] (s_q.req && s_q.cd == fbp_pkg::D_UNLK1 && s_q.ca == U1);
  endsequence

  a_prog_unlock: assert property (
    s_q.req && s_q.wr && s_q.op == fbp_pkg::OP_PROG && s_q.step == 6'h02
    |-> s_q.cd == fbp_pkg::D_LOAD && s_q.ca == s_q.addr
        && $past(s_q.cd, 6) == fbp_pkg::D_UNLK2)
    else $error("load command not after unlock");
  a_count_word: assert property (
    s_q.req && s_q.wr && s_q.op == fbp_pkg::OP_PROG && s_q.step == 6'h03
    |-> s_q.cd == {10'h000, s_q.cnt} && !s_q.cnt[5])
    else $error("bad word count write");
  a_confirm_cmd: assert property (
    s_q.req && s_q.wr && s_q.op == fbp_pkg::OP_PROG
    && s_q.step == s_q.cnt + 6'h05
    |-> s_q.cd == fbp_pkg::D_CONF && s_q.ca == s_q.addr)
    else $error("confirm missing");
  a_page_same: assert property (
    s_q.req && s_q.wr && s_q.op == fbp_pkg::OP_PROG && s_q.step > 6'h03
    |-> s_q.ca[AW-1:5] == s_q.addr[AW-1:5])
    else $error("load left the page");
  a_erase_setup: assert property (
    s_q.req && s_q.op == fbp_pkg::OP_ERASE && s_q.step == 6'h02
    |-> s_q.cd == fbp_pkg::D_ESET && s_q.ca == U1 ##0 s_erase_tail)
    else $error("erase setup order wrong");
  a_abort_reset: assert property (
    s_q.req && s_q.op == fbp_pkg::OP_ABRST && s_q.step == 6'h02
    |-> s_q.cd == fbp_pkg::D_ABRST && s_q.ca == U1)
    else $error("abort reset word wrong");
  a_add_window: assert property (
    s_q.st == S_ISSUE && s_q.op == fbp_pkg::OP_ADD
    && $past(s_q.st) == S_WIN
    |-> $past(s_q.wtmr) < 10'(fbp_pkg::ADD_ACC_CYC))
    else $error("sector added too late");
  a_poll_abort: assert property (
    s_q.st == S_RW && cyc.done && s_q.sec && s_q.op == fbp_pkg::OP_PROG
    && s_q.r1[fbp_pkg::TOGGLE_BIT_POS] != cyc.rdata[fbp_pkg::TOGGLE_BIT_POS]
    && s_q.r1[fbp_pkg::BUFFER_ABORT_POS]
    && cyc.rdata[fbp_pkg::BUFFER_ABORT_POS]
    |=> s_q.fl[fbp_pkg::ST_ABORT] && s_q.st == S_IDLE)
    else $error("abort not reported");
  a_hrst_pulse: assert property (
    $fell(s_q.rst_n) |-> s_rst_low ##1 !s_q.rst_n ##1 !s_q.rst_n
    ##1 s_q.rst_n)
    else $error("reset pulse length wrong");
endmodule

/* test/fbp_flash_host_tb.sv */
module fbp_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] fl_addr;
  logic [15:0] fl_dq_o;
  logic        fl_dq_oe;
  logic [15:0] fl_dq_i;
  logic        fl_ce_n;
  logic        fl_we_n;
  logic        fl_oe_n;
  logic        fl_rst_n;
  logic [31:0] q;
  logic        err;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          i;
  always #50 pclk = ~pclk;
  fbp_flash_host fbp_flash_host_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_rst_n(fl_rst_n));
  fbp_flash_model fbp_flash_model_i (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_rst_n(fl_rst_n));
  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int b, input logic v);
    for (int k = 0; k < 300 && q[b] !== v; k++)
      rd(fbp_pkg::R_STAT);
    chk("status_wait", {31'h0, v}, {31'h0, q[b]});
  endtask
  task automatic start_op(input logic [31:0] op);
    fbp_flash_model_i.wa.delete();
    fbp_flash_model_i.wd.delete();
    wr(fbp_pkg::R_STAT, 32'h0000_00FF);
    q = 32'h0;
    wr(fbp_pkg::R_CTRL, op);
  endtask
  task automatic seq(input int n, input logic [23:0] a, input logic [15:0] d);
    chk("flash_addr", {8'h00, a}, {8'h00, fbp_flash_model_i.wa[n]});
    chk("flash_data", {16'h0, d}, {16'h0, fbp_flash_model_i.wd[n]});
  endtask
  task automatic prog(input logic [31:0] a, input int n,
                      input logic [31:0] op);
    for (i = 0; i < n; i++)
      wr(8'(fbp_pkg::R_BUF + 4 * i), 32'h1230 + 32'(i));
    wr(fbp_pkg::R_ADDR, a);
    wr(fbp_pkg::R_CNT, 32'(n - 1));
    start_op(op);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("rst_n", 32'h1, {31'h0, fl_rst_n});
    rd(fbp_pkg::R_STAT);
    chk("stat_reset", 32'h0, q);
    rd(8'h14);
    chk("unmapped", 32'h1, {31'h0, err});
    prog(32'h1000, 4, 32'h1);
    wt(fbp_pkg::ST_DONE, 1'b1);
    seq(0, 24'h555, 16'h00AA);
    seq(1, 24'h2AA, 16'h0055);
    seq(2, 24'h1000, 16'h0025);
    seq(3, 24'h1000, 16'h0003);
    seq(7, 24'h1003, 16'h1233);
    seq(8, 24'h1000, 16'h0029);
    prog(32'h2000, 32, 32'h1);
    wt(fbp_pkg::ST_DONE, 1'b1);
    seq(35, 24'h201F, 16'h124F);
    chk("cycles", 32'h25, 32'(fbp_flash_model_i.wa.size()));
    prog(32'h2001, 32, 32'h1);
    rd(fbp_pkg::R_STAT);
    chk("page_reject", 32'h1, {31'h0, q[fbp_pkg::ST_REJ]});
    chk("no_cycles", 32'h0, 32'(fbp_flash_model_i.wa.size()));
    fbp_flash_model_i.bad = 1'b1;
    prog(32'h1000, 1, 32'h1);
    wt(fbp_pkg::ST_ABORT, 1'b1);
    fbp_flash_model_i.bad = 1'b0;
    start_op(32'h4);
    wt(fbp_pkg::ST_DONE, 1'b1);
    seq(2, 24'h555, 16'h00F0);
    chk("abort_clear", 32'h0, {31'h0, fbp_flash_model_i.ab});
    fbp_flash_model_i.tl = 1'b1;
    prog(32'h1000, 1, 32'h1);
    wt(fbp_pkg::ST_ERR, 1'b1);
    fbp_flash_model_i.tl = 1'b0;
    wr(fbp_pkg::R_ADDR, 32'h10000);
    start_op(32'h2);
    wt(fbp_pkg::ST_WIN, 1'b1);
    wr(fbp_pkg::R_ADDR, 32'h30000);
    wr(fbp_pkg::R_CTRL, 32'h3);
    wr(fbp_pkg::R_CTRL, 32'h1);
    rd(fbp_pkg::R_STAT);
    chk("window_reject", 32'h1, {31'h0, q[fbp_pkg::ST_REJ]});
    wt(fbp_pkg::ST_DONE, 1'b1);
    seq(2, 24'h555, 16'h0080);
    seq(5, 24'h10000, 16'h0030);
    seq(6, 24'h30000, 16'h0030);
    chk("sectors", 32'h2, 32'(fbp_flash_model_i.nsec));
    rd(fbp_pkg::R_RDAT);
    chk("erased", 32'h0000_FFFF, q);
    start_op(32'h2);
    wt(fbp_pkg::ST_WIN, 1'b1);
    wt(fbp_pkg::ST_WIN, 1'b0);
    wt(fbp_pkg::ST_ETMR, 1'b1);
    wr(fbp_pkg::R_CTRL, 32'h5);
    wt(fbp_pkg::ST_INTR, 1'b1);
    chk("erase_stopped", 32'h0, 32'(fbp_flash_model_i.busy));
    print_verdict();
  end
endmodule

/* test/fbp_flash_model.sv */
module fbp_flash_model (
  input  logic [23:0] fl_addr,
  input  logic [15:0] fl_dq_o,
  input  logic        fl_dq_oe,
  output logic [15:0] fl_dq_i,
  input  logic        fl_ce_n,
  input  logic        fl_we_n,
  input  logic        fl_oe_n,
  input  logic        fl_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Command decode, one step per strobe rise
  // ==========================================================
  logic [23:0] wa[$];
  logic [15:0] wd[$];
  logic [15:0] mem[int];
  logic [15:0] bf[int];
  int          s = 0;
  int          left;
  int          page;
  int          sec;
  int          busy = 0;
  int          nsec = 0;
  logic        tog = 1'b0;
  logic        ab = 1'b0;
  logic        er = 1'b0;
  logic        bad = 1'b0;
  logic        tl = 1'b0;
  logic [15:0] lastd = 16'h0000;
  logic [15:0] rd = 16'h0000;
  wire         a5 = fl_addr[11:0] == 12'h555;
  wire         u1 = a5 && fl_dq_o == 16'h00AA;
  wire         u2 = fl_addr[11:0] == 12'h2AA && fl_dq_o == 16'h0055;
  assign fl_dq_i = rd;
  always @(posedge fl_we_n)
  begin
    if (fl_rst_n && !fl_ce_n && busy == 0)
    begin
      wa.push_back(fl_addr);
      wd.push_back(fl_dq_o);
      if (s == 2 && a5 && fl_dq_o == 16'h00F0)
      begin
        ab = 1'b0;
        bf.delete();
      end
      if (s == 2)
        sec = int'(fl_addr);
      if (s == 22)
        nsec = 0;
      case (s)
        0: s = u1 ? 1 : 0;
        1, 21: s = u2 ? s + 1 : 0;
        2: s = fl_dq_o == 16'h0025 ? 10 : (fl_dq_o == 16'h0080 && a5) ? 20 : 0;
        10:
        begin
          left = int'(fl_dq_o) + 1;
          page = -1;
          bf.delete();
          s = fl_dq_o > 16'h001F ? 40 : 11;
        end
        11:
        begin
          if (page < 0)
            page = int'(fl_addr >> 5);
          bf[fl_addr] = fl_dq_o;
          lastd = fl_dq_o;
          left--;
          s = int'(fl_addr >> 5) != page ? 40 : left == 0 ? 12 : 11;
        end
        12: s = fl_dq_o == 16'h0029 && fl_addr == sec && !bad ? 50 : 40;
        20: s = u1 ? 21 : 0;
        22, 30: s = fl_dq_o == 16'h0030 ? 30 : 0;
        default: s = 0;
      endcase
      if (s == 30)
        nsec++;
      if (s == 40)
        ab = 1'b1;
      if (s == 50)
        busy = tl ? 2 : 4;
      if (s >= 40)
        s = 0;
    end
  end
  // ==========================================================
  // Status and array reads
  // ==========================================================
  always @(negedge fl_oe_n)
  begin
    if (s == 30)
    begin
      er = 1'b1;
      busy = 40;
      s = 0;
    end
    if (busy > 0 || ab)
    begin
      tog = ~tog;
      rd = {8'h00, ~lastd[7], tog, tl, 1'b0, er, 1'b0, ab, 1'b0};
      busy = busy > 0 ? busy - 1 : 0;
    end
    else
    begin
      foreach (bf[k])
        mem[k] = bf[k];
      bf.delete();
      er = 1'b0;
      rd = mem.exists(int'(fl_addr)) ? mem[int'(fl_addr)] : 16'hFFFF;
    end
  end
  // Released bus shows the inverse, never a stale copy
  always @(posedge fl_oe_n)
    rd = ~rd;
  always @(negedge fl_rst_n)
  begin
    busy = 0;
    s = 0;
    ab = 1'b0;
    er = 1'b0;
  end
endmodule
